// ===== rvip_top.sv
`timescale 1ns/1ps
module rvip_top
  import rvip_pkg::*;
#(
  parameter int NS = 17                      // Maskable source count
) (
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire logic                  rst_pin,       // Power-on or pin reset
  input  wire logic                  clk_fail,      // Clock monitor failure
  input  wire logic                  wdog_timeout,  // Watchdog expiry
  input  wire logic                  mode_pin_a,
  input  wire logic                  mode_pin_b,
  input  wire logic [7:0]            nv_cells,      // Nonvolatile latch source
  input  wire logic                  nmi_pin,       // Non-maskable pin request
  input  wire logic                  illegal_op,    // Illegal opcode trap
  input  wire logic                  mask_i,        // CPU global maskable inhibit
  input  wire logic                  mask_x,        // CPU non-maskable pin inhibit
  input  wire logic [NS-1:0]         irq_req,       // Requests in default rank order
  input  wire logic [NS-1:0]         irq_en,        // Local enables
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  output rvip_pkg::rvip_cpu_t        cpu_start,
  output rvip_pkg::rvip_periph_t     periph_init,
  output logic                       irq_valid,
  output logic [15:0]                irq_vector,
  output logic [2:0]                 nmi_sel,       // 1 pin, 2 trap, 0 none
  output logic                       rom_upper,
  output logic                       rom_mapped,
  output logic                       nv_mapped,
  output logic                       pullups_on,
  output logic                       security_on,
  output logic                       watchdog_on,
  output logic                       expansion_bus,
  output logic [7:0]                 nv_placement,
  output logic [3:0]                 option_q
);
  import rvip_pkg::*;

  // Start-up sequencing states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN   = 2'b10
  } rvip_state_t;

  rvip_state_t     state_q;           // Sequencer state
  logic [1:0]      fetch_cnt_q;       // Vector fetch cycle count
  rvip_cause_t     cause_q;           // Latest reset cause
  logic [7:0]      cfg_q;             // Configuration latch
  logic [7:0]      pri_q;             // Priority register
  logic [3:0]      opt_q;             // Option bits
  logic            in_reset;          // Any reset source active
  logic            special;           // Special test or bootstrap

  // Reset source priority: pin beats clock beats watchdog
  rvip_cause_t     cause_d;
  assign in_reset = srst | rst_pin | clk_fail | wdog_timeout;
  assign cause_d  = (srst | rst_pin) ? CAUSE_POR :
                    clk_fail         ? CAUSE_CLK : CAUSE_WDG;
  assign special  = pri_q[PRI_SPECIAL_MODE_BIT];

  // Register decode
  wire wr_cfg = reg_wr & (reg_addr == REG_CFG_LATCH);
  wire wr_pri = reg_wr & (reg_addr == REG_PRIORITY);
  wire wr_opt = reg_wr & (reg_addr == REG_OPTION);
  wire cfg_ok = wr_cfg & special;
  wire pri_ok = wr_pri & mask_i;
  wire mode_ok = pri_ok & special;

  // Reset vector by cause and mode
  logic [15:0] rst_vec;
  always_comb begin
    case (cause_q)
      CAUSE_POR: rst_vec = special ? VEC_POR_SPEC : VEC_POR_NORM;
      CAUSE_CLK: rst_vec = special ? VEC_CLK_SPEC : VEC_CLK_NORM;
      CAUSE_WDG: rst_vec = special ? VEC_WDG_SPEC : VEC_WDG_NORM;
      default:   rst_vec = VEC_POR_NORM;
    endcase
  end

  // Promoted source index from select code
  wire        psel_valid = (pri_q[4:0] >= PSEL_FIRST) && (pri_q[4:0] <= PSEL_LAST);
  wire [4:0]  psel_off   = pri_q[4:0] - PSEL_FIRST;
  // Code order is rank order except the three serial ports
  logic [4:0] promo_rank;
  always_comb begin
    if (!psel_valid) begin
      promo_rank = 5'h00;
    end else begin
      case (psel_off)
        5'h0A:   promo_rank = 5'h0C;   // Timer overflow
        5'h0B:   promo_rank = 5'h0D;   // Accumulator overflow
        5'h0C:   promo_rank = 5'h0E;   // Accumulator edge
        5'h0D:   promo_rank = 5'h0F;   // SPI
        5'h0E:   promo_rank = 5'h10;   // Serial one
        5'h0F:   promo_rank = 5'h0A;   // Serial two
        5'h10:   promo_rank = 5'h0B;   // Serial three
        default: promo_rank = psel_off;
      endcase
    end
  end

  // Unmasked requests per source
  logic [NS-1:0] live;
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_live
      assign live[g] = irq_req[g] & irq_en[g] & ~mask_i;
    end
  endgenerate

  // Winner: promoted if live, else lowest rank index
  logic [4:0] win;
  logic       any_live;
  always_comb begin
    win      = 5'h00;
    any_live = 1'b0;
    for (int i = NS-1; i >= 0; i--) begin
      if (live[i]) begin
        win      = 5'(i);
        any_live = 1'b1;
      end
    end
    if (live[promo_rank]) begin
      win = promo_rank;
    end
  end
  wire [15:0] win_vec = VEC_IRQ_BASE - {10'h000, win, 1'b0};

  // Non-maskable pending: pin before trap
  wire [2:0] nmi_d = (nmi_pin & ~mask_x) ? 3'h1 :
                     illegal_op ? 3'h2 : 3'h0;

  // Sequencer and captured state
  always_ff @(posedge ref_clk) begin
    if (in_reset) begin
      state_q     <= ST_RESET;
      fetch_cnt_q <= 2'h0;
      cause_q     <= cause_d;
      pri_q       <= {3'h0, PSEL_RESET};
      opt_q       <= OPT_RESET;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_q     <= ST_FETCH;
          cfg_q       <= nv_cells | CFG_ONES_MASK;
          pri_q[7:5]  <= {mode_pin_b & ~mode_pin_a, ~mode_pin_b, mode_pin_a};
        end
        ST_FETCH: begin
          fetch_cnt_q <= fetch_cnt_q + 2'h1;
          if (fetch_cnt_q == 2'(FETCH_CYCLES - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cfg_ok) begin
            cfg_q <= reg_wdata | CFG_ONES_MASK;
          end
          if (pri_ok) begin
            pri_q[4:0] <= reg_wdata[4:0];
          end
          if (mode_ok) begin
            pri_q[7:5] <= reg_wdata[7:5];
          end
          if (wr_opt) begin
            opt_q[OPT_CONVERTER_POWER_UP] <= reg_wdata[OPT_CONVERTER_POWER_UP];
            opt_q[OPT_CME]  <= reg_wdata[OPT_CME];
            opt_q[OPT_CLOCK_MONITOR_FORCE] <= opt_q[OPT_CLOCK_MONITOR_FORCE] | reg_wdata[OPT_CLOCK_MONITOR_FORCE];
            if (special) begin
              opt_q[OPT_DLY] <= reg_wdata[OPT_DLY];
            end
          end
        end
        default: state_q <= ST_RESET;
      endcase
    end
  end

  // Read data one cycle after strobe
  wire [7:0] rd_mux =
    (reg_addr == REG_CFG_LATCH) ? cfg_q :
    (reg_addr == REG_PRIORITY)  ? pri_q :
    (reg_addr == REG_NV_CELLS)  ? nv_cells :
    (reg_addr == REG_STATUS)    ? {any_live, nmi_d, state_q, cause_q} :
    (reg_addr == REG_OPTION)    ? {4'h0, opt_q} : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // CPU start bundle
  always_ff @(posedge ref_clk) begin
    if (in_reset) begin
      cpu_start <= '0;
    end else begin
      cpu_start.fetch        <= (state_q == ST_FETCH);
      cpu_start.vector       <= rst_vec;
      cpu_start.mask_x       <= 1'b1;
      cpu_start.mask_i       <= 1'b1;
      cpu_start.stop_inhibit <= 1'b1;
    end
  end

  // Peripheral reset images
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      periph_init <= '0;
    end else begin
      periph_init.timer_count       <= 16'h0000;
      periph_init.timer_prescale    <= 2'h0;
      periph_init.compare_init      <= 16'hFFFF;
      periph_init.compare1_pin_mask <= 8'h00;
      periph_init.timer_irq_en      <= 9'h000;
      periph_init.timer_flags       <= 9'h000;
      periph_init.baud_init         <= 16'h0004;
      periph_init.transmit_empty_flag    <= 1'b1;
      periph_init.transmit_complete_flag <= 1'b1;
      periph_init.receive_full_flag      <= 1'b0;
      periph_init.serial_enables    <= 1'b0;
      periph_init.alt_bus_enable    <= 1'b0;
      periph_init.spi_enable        <= 1'b0;
      periph_init.accumulator_enable <= 1'b0;
      periph_init.periodic_interrupt_flag <= 1'b0;
      periph_init.periodic_ctrl     <= 3'h0;
      periph_init.converter_done    <= 1'b0;
    end
  end

  // Map controls and interrupt outputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_valid     <= 1'b0;
      irq_vector    <= 16'h0000;
      nmi_sel       <= 3'h0;
      rom_upper     <= 1'b1;
      rom_mapped    <= 1'b0;
      nv_mapped     <= 1'b0;
      pullups_on    <= 1'b0;
      security_on   <= 1'b1;
      watchdog_on   <= 1'b0;
      expansion_bus <= 1'b0;
      nv_placement  <= 8'h00;
      option_q      <= OPT_RESET;
    end else begin
      irq_valid     <= any_live & (state_q == ST_RUN);
      irq_vector    <= win_vec;
      nmi_sel       <= (state_q == ST_RUN) ? nmi_d : 3'h0;
      // Lower half allowed only in expanded mode
      rom_upper     <= cfg_q[CFG_ROM_PLACE] | ~pri_q[PRI_MDA];
      rom_mapped    <= cfg_q[CFG_ROM_EN];
      nv_mapped     <= cfg_q[CFG_NV_EN];
      pullups_on    <= cfg_q[CFG_PULLUP];
      security_on   <= ~cfg_q[CFG_SEC_OFF];
      watchdog_on   <= ~cfg_q[CFG_WDOG_OFF];
      expansion_bus <= pri_q[PRI_MDA];
      nv_placement  <= in_reset ? 8'h00 : nv_placement;
      option_q      <= opt_q;
    end
  end

  // Checks
  a_cfg_reserved_ones: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q == ST_RUN) |-> (cfg_q[6:5] == 2'b11)) else $error("latch unused bits not one");
  a_cfg_hold_normal: assert property (@(posedge ref_clk) disable iff (in_reset)
    (state_q == ST_RUN) && !special |=> $stable(cfg_q)) else $error("latch changed in normal mode");
  a_pri_write_gate: assert property (@(posedge ref_clk) disable iff (in_reset)
    (state_q == ST_RUN) && wr_pri && !mask_i |=> $stable(pri_q[4:0])) else $error("priority written unmasked");
  a_fetch_bound: assert property (@(posedge ref_clk) disable iff (in_reset)
    (state_q == ST_FETCH) |-> ##[0:3] (state_q == ST_RUN)) else $error("vector fetch too long");
  a_vec_normal: assert property (@(posedge ref_clk) disable iff (in_reset)
    cpu_start.fetch && !special && cause_q == CAUSE_POR |-> cpu_start.vector == 16'hFFFE) else $error("bad normal vector");
  a_vec_special: assert property (@(posedge ref_clk) disable iff (in_reset)
    cpu_start.fetch && special && cause_q == CAUSE_WDG |-> cpu_start.vector == 16'hBFFA) else $error("bad special vector");
  a_psel_reset: assert property (@(posedge ref_clk)
    $past(in_reset) |-> pri_q[4:0] == 5'h06) else $error("priority not reset");
  a_irq_masked: assert property (@(posedge ref_clk) disable iff (srst)
    $past(mask_i) |-> !irq_valid) else $error("request passed global mask");
  // Latch is unknown until its first load, so start once the load edge has passed
  a_wdog_follow: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q != ST_RESET) |=> watchdog_on == !$past(cfg_q[CFG_WDOG_OFF])) else $error("watchdog enable wrong");
  a_promo_wins: assert property (@(posedge ref_clk) disable iff (srst)
    live[promo_rank] |=> irq_vector == VEC_IRQ_BASE - {10'h000, $past(promo_rank), 1'b0}) else $error("promoted lost");
endmodule

// ===== rvip_pkg.sv
package rvip_pkg;
  // Register offsets (own map, byte addresses)
  localparam logic [7:0] REG_CFG_LATCH  = 8'h00;  // Configuration latch
  localparam logic [7:0] REG_PRIORITY   = 8'h04;  // Priority register
  localparam logic [7:0] REG_NV_CELLS   = 8'h08;  // Nonvolatile cell image
  localparam logic [7:0] REG_STATUS     = 8'h0C;  // Reset cause and pending
  localparam logic [7:0] REG_OPTION     = 8'h10;  // Option bits
  // Configuration latch fields
  localparam int CFG_ROM_PLACE = 7;
  localparam int CFG_PULLUP    = 4;
  localparam int CFG_SEC_OFF   = 3;
  localparam int CFG_WDOG_OFF  = 2;
  localparam int CFG_ROM_EN    = 1;
  localparam int CFG_NV_EN     = 0;
  localparam logic [7:0] CFG_ONES_MASK = 8'h60;   // Bits six and five
  // Priority register fields
  localparam int PRI_BOOT = 7;
  localparam int PRI_SPECIAL_MODE_BIT = 6;
  localparam int PRI_MDA  = 5;
  localparam logic [4:0] PSEL_RESET = 5'h06;      // External pin promoted
  localparam logic [4:0] PSEL_FIRST = 5'h06;      // Lowest valid code
  localparam logic [4:0] PSEL_LAST  = 5'h16;      // Highest valid code
  // Option bits reset value: stop delay set, clock monitor off
  localparam int OPT_CONVERTER_POWER_UP = 3;
  localparam int OPT_DLY  = 2;
  localparam int OPT_CME  = 1;
  localparam int OPT_CLOCK_MONITOR_FORCE = 0;
  localparam logic [3:0] OPT_RESET = 4'h4;
  // Reset and interrupt vectors
  localparam logic [15:0] VEC_POR_NORM  = 16'hFFFE;
  localparam logic [15:0] VEC_CLK_NORM  = 16'hFFFC;
  localparam logic [15:0] VEC_WDG_NORM  = 16'hFFFA;
  localparam logic [15:0] VEC_POR_SPEC  = 16'hBFFE;
  localparam logic [15:0] VEC_CLK_SPEC  = 16'hBFFC;
  localparam logic [15:0] VEC_WDG_SPEC  = 16'hBFFA;
  localparam logic [15:0] VEC_NONMASKABLE_IRQ_PIN      = 16'hFFF4;
  localparam logic [15:0] VEC_ILLOP     = 16'hFFF8;
  localparam logic [15:0] VEC_IRQ_BASE  = 16'hFFF2;  // Rank 0 vector; each rank two lower
  localparam int NSRC = 17;
  localparam int FETCH_CYCLES = 3;
  // Reset sources
  typedef enum logic [1:0] {
    CAUSE_POR = 2'b00,
    CAUSE_CLK = 2'b01,
    CAUSE_WDG = 2'b10
  } rvip_cause_t;
  // Peripheral reset-state bundle
  typedef struct packed {
    logic [15:0] timer_count;
    logic [1:0]  timer_prescale;
    logic [15:0] compare_init;
    logic [7:0]  compare1_pin_mask;
    logic [8:0]  timer_irq_en;
    logic [8:0]  timer_flags;
    logic [15:0] baud_init;
    logic        transmit_empty_flag;
    logic        transmit_complete_flag;
    logic        receive_full_flag;
    logic        serial_enables;
    logic        alt_bus_enable;
    logic        spi_enable;
    logic        accumulator_enable;
    logic        periodic_interrupt_flag;
    logic [2:0]  periodic_ctrl;
    logic        converter_done;
  } rvip_periph_t;
  // CPU start bundle
  typedef struct packed {
    logic        fetch;
    logic [15:0] vector;
    logic        mask_x;
    logic        mask_i;
    logic        stop_inhibit;
  } rvip_cpu_t;
endpackage

// ===== rvip_cpu_model.sv
`timescale 1ns/1ps
// Stand-in CPU core: owns the condition-code masks and takes the start vector
module rvip_cpu_model
  import rvip_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,    // Any reset source
  input  wire rvip_pkg::rvip_cpu_t  cpu_start,  // Start bundle from the block
  input  wire logic                 sw_mask_i,  // Software choice for I mask
  input  wire logic                 sw_mask_x,  // Software choice for X mask
  output logic                      mask_i,
  output logic                      mask_x,
  output logic [15:0]               fetch_vec   // Last start vector taken
);
  logic run_q;  // Set once the start vector was taken

  // Masks forced through reset and fetch, software owns them afterwards
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mask_i <= 1'b1;
      mask_x <= 1'b1;
      run_q  <= 1'b0;
    end else if (cpu_start.fetch) begin
      mask_i    <= cpu_start.mask_i;
      mask_x    <= cpu_start.mask_x;
      fetch_vec <= cpu_start.vector;
      run_q     <= 1'b1;
    end else if (run_q) begin
      // Software holds I set around priority changes
      mask_i <= sw_mask_i;
      mask_x <= sw_mask_x;
    end
  end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rvip_pkg::*;
  logic          ref_clk, srst, rst_pin, clk_fail, wdog_timeout;  // Clock and reset sources
  logic          mode_pin_a, mode_pin_b, nmi_pin, illegal_op;     // Mode and trap inputs
  logic          mask_i, mask_x, sw_mask_i, sw_mask_x;            // Masks via CPU model
  logic [7:0]    nv_cells, reg_addr, reg_wdata, reg_rdata, nv_placement;
  logic          reg_wr, reg_rd, irq_valid, rom_upper, rom_mapped, nv_mapped;
  logic          pullups_on, security_on, watchdog_on, expansion_bus;
  logic [16:0]   irq_req, irq_en;
  logic [15:0]   irq_vector, fetch_vec;
  logic [2:0]    nmi_sel;
  logic [3:0]    option_q;
  rvip_cpu_t     cpu_start;
  rvip_periph_t  periph_init;
  logic [31:0]   seed = 32'hCC85246B;  // Fixed random seed
  int            err_total = 0;
  int            comparisons = 0;

  rvip_top dut (.ref_clk(ref_clk), .srst(srst), .rst_pin(rst_pin), .clk_fail(clk_fail),
    .wdog_timeout(wdog_timeout), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .nv_cells(nv_cells),
    .nmi_pin(nmi_pin), .illegal_op(illegal_op), .mask_i(mask_i), .mask_x(mask_x), .irq_req(irq_req),
    .irq_en(irq_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_start(cpu_start), .periph_init(periph_init), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .nmi_sel(nmi_sel), .rom_upper(rom_upper), .rom_mapped(rom_mapped),
    .nv_mapped(nv_mapped), .pullups_on(pullups_on), .security_on(security_on), .watchdog_on(watchdog_on),
    .expansion_bus(expansion_bus), .nv_placement(nv_placement), .option_q(option_q));
  rvip_cpu_model cpu (.ref_clk(ref_clk), .sys_rst(srst | rst_pin | clk_fail | wdog_timeout),
    .cpu_start(cpu_start), .sw_mask_i(sw_mask_i), .sw_mask_x(sw_mask_x), .mask_i(mask_i),
    .mask_x(mask_x), .fetch_vec(fetch_vec));

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Start vector for a cause in normal or special mode
  function automatic logic [15:0] vec_of(input int cause, input logic spec);
    return (spec ? 16'hBFFE : 16'hFFFE) - 16'(2 * cause);
  endfunction
  // Winning vector: promoted source first, then default rank
  function automatic logic [15:0] exp_vec(input logic [4:0] code, input logic [16:0] p);
    int pr;
    int i;
    pr = (code >= 5'h06 && code <= 5'h0F) ? int'(code) - 6 : (code >= 5'h10 && code <= 5'h13) ?
      int'(code) - 4 : (code == 5'h14) ? 16 : (code == 5'h15) ? 10 : (code == 5'h16) ? 11 : 0;
    if (!p[pr]) begin
      for (i = 16; i >= 0; i--) if (p[i]) pr = i;
    end
    return 16'hFFF2 - 16'(2 * pr);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Reset from one source, then await the start fetch
  task automatic do_reset(input int cause, input logic b, input logic a);
    int i;
    @(posedge ref_clk);
    {mode_pin_b, mode_pin_a} <= {b, a};
    {wdog_timeout, clk_fail, rst_pin} <= 3'(1 << cause);
    tick(3);
    {wdog_timeout, clk_fail, rst_pin} <= 3'h0;
    for (i = 1; i <= 8; i++) begin
      @(posedge ref_clk);
      #1;
      if (cpu_start.fetch === 1'b1) break;
    end
    if (i > 8) begin
      err_total++;
      results();
    end else begin
      check(16'(i <= FETCH_CYCLES), 16'h0001);
      check(16'({cpu_start.mask_x, cpu_start.mask_i, cpu_start.stop_inhibit}), 16'h0007);
      tick(6);
      check(fetch_vec, vec_of(cause, ~b));
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    logic [31:0] r;
    logic [16:0] p;
    logic [7:0]  d, nv;
    logic        a, b;
    int          c, m, k;
    {srst, rst_pin, clk_fail, wdog_timeout, nmi_pin, illegal_op, reg_wr, reg_rd} = 8'h80;
    {sw_mask_i, sw_mask_x, mode_pin_b, mode_pin_a} = 4'hF;
    {nv_cells, reg_addr, reg_wdata, irq_req, irq_en} = '0;
    tick(3);
    srst <= 1'b0;
    tick(8);
    check(16'({periph_init.transmit_empty_flag, periph_init.transmit_complete_flag, periph_init.receive_full_flag,
      periph_init.serial_enables, periph_init.alt_bus_enable, periph_init.spi_enable}), 16'h0030);
    check(16'({periph_init.accumulator_enable, periph_init.periodic_interrupt_flag, periph_init.periodic_ctrl,
      periph_init.converter_done, option_q}), 16'h0004);
    check(periph_init.baud_init, 16'h0004);
    check(periph_init.compare_init, 16'hFFFF);
    check(periph_init.timer_count | 16'(periph_init.timer_prescale) | 16'(periph_init.compare1_pin_mask), 16'h0);
    check(16'(periph_init.timer_flags | periph_init.timer_irq_en), 16'h0);
    check(16'(nv_placement), 16'h0);
    // Option writes in normal mode: delay bit kept, force bit sticky
    wr(REG_OPTION, 8'h0F);
    wr(REG_OPTION, 8'h00);
    rd(REG_OPTION, d);
    check(16'(d), 16'h0005);
    check(16'(option_q), 16'h0005);
    rd(REG_NV_CELLS, d);
    check(16'(d), 16'h0000);
    $display("test reset_state done");
    for (c = 0; c < 3; c++) for (m = 0; m < 4; m++) begin
      b = (m == 0) || (m == 3);
      a = (m < 2);
      r = rnd();
      nv = r[7:0];
      nv_cells <= nv;
      do_reset(c, b, a);
      nv_cells <= ~nv;
      check(16'(rom_upper), 16'(a ? nv[7] : 1'b1));
      check(16'(expansion_bus), 16'(a));
      rd(REG_PRIORITY, d);
      check(16'(d), 16'({b & ~a, ~b, a, PSEL_RESET}));
      if (a) begin
        check(16'({pullups_on, security_on, watchdog_on, rom_mapped, nv_mapped}),
          16'({nv[4], ~nv[3], ~nv[2], nv[1], nv[0]}));
        rd(REG_CFG_LATCH, d);
        check(16'(d), 16'(nv | CFG_ONES_MASK));
        r = rnd();
        wr(REG_CFG_LATCH, r[7:0]);
        rd(REG_CFG_LATCH, d);
        check(16'(d), 16'((b ? nv : r[7:0]) | CFG_ONES_MASK));
      end
    end
    $display("test vectors_and_latch done");
    do_reset(0, 1'b1, 1'b1);
    sw_mask_i <= 1'b0;
    tick(3);
    wr(REG_PRIORITY, 8'h10);
    rd(REG_PRIORITY, d);
    check(16'(d), 16'h0026);
    for (c = 0; c < 32; c++) begin
      @(posedge ref_clk);
      sw_mask_i <= 1'b1;
      irq_req <= '1;
      irq_en <= '1;
      tick(3);
      r = rnd();
      wr(REG_PRIORITY, {r[7:5], 5'(c)});
      rd(REG_PRIORITY, d);
      check(16'(d), 16'({3'b001, 5'(c)}));
      check(16'(irq_valid), 16'h0);
      sw_mask_i <= 1'b0;
      tick(3);
      #1;
      check(irq_vector, exp_vec(5'(c), '1));
      for (k = 0; k < 4; k++) begin
        @(posedge ref_clk);
        r = rnd();
        irq_req <= r[16:0];
        p = r[16:0];
        r = rnd();
        irq_en <= r[16:0];
        p = p & r[16:0];
        tick(2);
        #1;
        check(16'(irq_valid), 16'(|p));
        if (|p) check(irq_vector, exp_vec(5'(c), p));
      end
    end
    $display("test priority done");
    for (k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      {sw_mask_x, illegal_op, nmi_pin} <= 3'(k);
      tick(3);
      #1;
      check(16'(nmi_sel), ((k & 5) == 1) ? 16'h1 : (k & 2) ? 16'h2 : 16'h0);
    end
    $display("test nonmaskable done");
    results();
  end
endmodule
